// >>> design/hsc_defs.svh
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// Register offsets on the configuration port (byte addresses)
`define HSC_OFS_CTRL        8'h74
`define HSC_OFS_IRQ_STATUS  8'h80
`define HSC_OFS_IRQ_ENABLE  8'h84
`define HSC_OFS_IRQ_CLEAR   8'h88

// Field positions of the hot-swap control and status word
`define HSC_CAP_ID_LSB      0
`define HSC_CAP_ID_MSB      7
`define HSC_NEXT_PTR_LSB    8
`define HSC_NEXT_PTR_MSB    15
`define HSC_HIDE_ARM_BIT    16
`define HSC_ENUM_MASK_BIT   17
`define HSC_PENDING_BIT     18
`define HSC_LED_BIT         19
`define HSC_PI_LSB          20
`define HSC_PI_MSB          21
`define HSC_EXT_BIT         22
`define HSC_INS_BIT         23

// Constant field values and reset values
`define HSC_CAP_ID_ON       8'h06
`define HSC_CAP_ID_OFF      8'h00
`define HSC_NEXT_PTR_VAL    8'h00
`define HSC_PI_CODE         2'h1
`define HSC_INS_RESET       1'b1
`define HSC_EXT_RESET       1'b0
`define HSC_CTRL_BIT_RESET  1'b0
`define HSC_IRQ_RESET       2'h0

// Interrupt status, enable and clear layout
`define HSC_IRQ_INS_BIT     0
`define HSC_IRQ_EXT_BIT     1

`endif

// >>> design/hsc_pkg.sv
package hsc_pkg;

  // One-hot register select decoded from the port address
  typedef enum logic [3:0] {
    HSC_SEL_NONE     = 4'h0,
    HSC_SEL_CTRL     = 4'h1,
    HSC_SEL_IRQ_STAT = 4'h2,
    HSC_SEL_IRQ_EN   = 4'h4,
    HSC_SEL_IRQ_CLR  = 4'h8
  } hsc_sel_t;

  typedef logic [1:0] hsc_irq_t;

endpackage : hsc_pkg

// >>> design/hsc_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

module hsc_sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output var  logic flag
);

  logic next_flag;

  // Set wins so an event landing on a clear is never lost
  always_comb
  begin
    if (set)
      next_flag = 1'b1;
    else if (clr)
      next_flag = 1'b0;
    else
      next_flag = flag;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag <= RESET_VAL;
    else
      flag <= next_flag;
  end

endmodule : hsc_sticky_flag

`default_nettype wire

// >>> design/hsc_enum_drive.sv
`timescale 1ns/1ps
`default_nettype none

module hsc_enum_drive (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ins_flag,
  input  wire logic ext_flag,
  input  wire logic mask,
  output logic      enum_n_o,
  output var  logic enum_n_oe
);

  logic next_drive;

  // Open drain: only ever pulls low, the host side pull-up gives the high level
  assign enum_n_o = 1'b0;

  always_comb
  begin
    next_drive = (ins_flag | ext_flag) & ~mask;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      enum_n_oe <= 1'b0;
    else
      enum_n_oe <= next_drive;
  end

endmodule : hsc_enum_drive

`default_nettype wire

// >>> design/hsc_cap_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defs.svh"

// Notes on behaviour
// - Bits 7:0 read 06h with hot-swap strap high, 00h when low; read-only.
// - Bits 15:8 read-only zero, marking the end of the capability chain.
// - Bit 16 read-write, reset zero; one arms device hiding.
// - Bit 17 read-write, reset zero; one suppresses the enumeration request.
// - Bit 18 reads one when hiding armed or either status flag set.
// - Bit 19 read-write, reset zero; drives the board LED directly.
// - Bits 21:20 read-only, return programming interface code 01.
// - Bit 22 extraction flag, write one clears, reset zero; asserts request.
// - Bit 23 insertion flag, write one clears, reset one; asserts request.
module hsc_cap_reg
  import hsc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output var  logic [31:0]       RDATA,
  input  wire logic              HOT_SWAP_STRAP_ENABLE,
  input  wire logic              INSERTION_EVENT,
  input  wire logic              EXTRACTION_EVENT,
  output logic                   ENUM_REQ_N_O,
  output logic                   ENUM_REQ_N_OE,
  output logic                   LED_ON,
  output logic                   DEVICE_HIDE_ARMED,
  output logic                   IRQ
);

  function automatic hsc_sel_t decode(input logic [ADDR_W-1:0] a);
    hsc_sel_t s;
    s = HSC_SEL_NONE;
    if (a == ADDR_W'(`HSC_OFS_CTRL))
      s = HSC_SEL_CTRL;
    else if (a == ADDR_W'(`HSC_OFS_IRQ_STATUS))
      s = HSC_SEL_IRQ_STAT;
    else if (a == ADDR_W'(`HSC_OFS_IRQ_ENABLE))
      s = HSC_SEL_IRQ_EN;
    else if (a == ADDR_W'(`HSC_OFS_IRQ_CLEAR))
      s = HSC_SEL_IRQ_CLR;
    return s;
  endfunction : decode

  hsc_sel_t wr_sel;
  hsc_sel_t rd_sel;
  logic     ctrl_wr;

  assign wr_sel  = WR ? decode(ADDR) : HSC_SEL_NONE;
  assign rd_sel  = RD ? decode(ADDR) : HSC_SEL_NONE;
  assign ctrl_wr = (wr_sel == HSC_SEL_CTRL);

  // Strap is caught once after reset release, so a later wiggle cannot change the ID
  logic strap_seen;
  logic strap_hs;
  logic next_strap_seen;
  logic next_strap_hs;

  always_comb
  begin
    next_strap_seen = 1'b1;
    next_strap_hs   = strap_seen ? strap_hs : HOT_SWAP_STRAP_ENABLE;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      strap_seen <= 1'b0;
      strap_hs   <= 1'b0;
    end
    else
    begin
      strap_seen <= next_strap_seen;
      strap_hs   <= next_strap_hs;
    end
  end

  // Read-write control bits
  logic hide_arm;
  logic enum_mask;
  logic led;
  logic next_hide_arm;
  logic next_enum_mask;
  logic next_led;

  always_comb
  begin
    next_hide_arm  = hide_arm;
    next_enum_mask = enum_mask;
    next_led       = led;
    if (ctrl_wr)
    begin
      next_hide_arm  = WDATA[`HSC_HIDE_ARM_BIT];
      next_enum_mask = WDATA[`HSC_ENUM_MASK_BIT];
      next_led       = WDATA[`HSC_LED_BIT];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      hide_arm  <= `HSC_CTRL_BIT_RESET;
      enum_mask <= `HSC_CTRL_BIT_RESET;
      led       <= `HSC_CTRL_BIT_RESET;
    end
    else
    begin
      hide_arm  <= next_hide_arm;
      enum_mask <= next_enum_mask;
      led       <= next_led;
    end
  end

  assign LED_ON            = led;
  assign DEVICE_HIDE_ARMED = hide_arm;

  // Status flags: write one clears, write zero leaves alone
  logic ins_flag;
  logic ext_flag;

  hsc_sticky_flag #(
    .RESET_VAL (`HSC_INS_RESET)
  ) u_ins_flag (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .set   (INSERTION_EVENT),
    .clr   (ctrl_wr & WDATA[`HSC_INS_BIT]),
    .flag  (ins_flag)
  );

  hsc_sticky_flag #(
    .RESET_VAL (`HSC_EXT_RESET)
  ) u_ext_flag (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .set   (EXTRACTION_EVENT),
    .clr   (ctrl_wr & WDATA[`HSC_EXT_BIT]),
    .flag  (ext_flag)
  );

  hsc_enum_drive u_enum (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .ins_flag  (ins_flag),
    .ext_flag  (ext_flag),
    .mask      (enum_mask),
    .enum_n_o  (ENUM_REQ_N_O),
    .enum_n_oe (ENUM_REQ_N_OE)
  );

  logic pending;
  assign pending = hide_arm | ins_flag | ext_flag;

  // Interrupt status, enable and clear
  hsc_irq_t irq_stat;
  hsc_irq_t irq_en;
  hsc_irq_t next_irq_stat;
  hsc_irq_t next_irq_en;
  hsc_irq_t irq_evt;
  hsc_irq_t irq_clr;

  always_comb
  begin
    irq_evt = '0;
    irq_evt[`HSC_IRQ_INS_BIT] = INSERTION_EVENT;
    irq_evt[`HSC_IRQ_EXT_BIT] = EXTRACTION_EVENT;
    irq_clr = (wr_sel == HSC_SEL_IRQ_CLR) ? WDATA[1:0] : '0;
    next_irq_stat = irq_evt | (irq_stat & ~irq_clr);
    next_irq_en   = (wr_sel == HSC_SEL_IRQ_EN) ? WDATA[1:0] : irq_en;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      irq_stat <= `HSC_IRQ_RESET;
      irq_en   <= `HSC_IRQ_RESET;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
    end
  end

  assign IRQ = |(irq_stat & irq_en);

  // Read data, one cycle after the strobe; unmapped and write-only read zero
  logic [31:0] ctrl_word;
  logic [31:0] next_rdata;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[`HSC_CAP_ID_MSB:`HSC_CAP_ID_LSB]     = strap_hs ? `HSC_CAP_ID_ON
                                                               : `HSC_CAP_ID_OFF;
    ctrl_word[`HSC_NEXT_PTR_MSB:`HSC_NEXT_PTR_LSB] = `HSC_NEXT_PTR_VAL;
    ctrl_word[`HSC_HIDE_ARM_BIT]                   = hide_arm;
    ctrl_word[`HSC_ENUM_MASK_BIT]                  = enum_mask;
    ctrl_word[`HSC_PENDING_BIT]                    = pending;
    ctrl_word[`HSC_LED_BIT]                        = led;
    ctrl_word[`HSC_PI_MSB:`HSC_PI_LSB]             = `HSC_PI_CODE;
    ctrl_word[`HSC_EXT_BIT]                        = ext_flag;
    ctrl_word[`HSC_INS_BIT]                        = ins_flag;
    case (rd_sel)
      HSC_SEL_CTRL:     next_rdata = ctrl_word;
      HSC_SEL_IRQ_STAT: next_rdata = {30'h0, irq_stat};
      HSC_SEL_IRQ_EN:   next_rdata = {30'h0, irq_en};
      default:          next_rdata = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      RDATA <= '0;
    else
      RDATA <= next_rdata;
  end

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  logic ctrl_rd_q;
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      ctrl_rd_q <= 1'b0;
    else
      ctrl_rd_q <= (rd_sel == HSC_SEL_CTRL);
  end

  // Compare against the strap copy of the read cycle, it is caught one edge after release
  cap_id_read_a: assert property (
    ctrl_rd_q |-> RDATA[7:0] == ($past(strap_hs) ? 8'h06 : 8'h00))
    else $error("capability id wrong for strap");

  next_ptr_zero_a: assert property (
    ctrl_rd_q |-> RDATA[15:8] == 8'h00)
    else $error("next capability pointer not zero");

  hide_arm_write_a: assert property (
    ctrl_wr |=> DEVICE_HIDE_ARMED == $past(WDATA[16]))
    else $error("hide arm did not follow write");

  mask_suppress_a: assert property (
    enum_mask |=> !ENUM_REQ_N_OE)
    else $error("enumeration request driven while masked");

  pending_read_a: assert property (
    ctrl_rd_q |-> RDATA[18] == $past(hide_arm | ins_flag | ext_flag))
    else $error("pending bit does not match flags");

  led_follow_a: assert property (
    ctrl_wr ##1 !ctrl_wr [*2] |-> LED_ON == $past(WDATA[19], 2))
    else $error("LED does not hold written value");

  pi_code_a: assert property (
    ctrl_rd_q |-> RDATA[21:20] == 2'b01 && RDATA[31:24] == 8'h00)
    else $error("programming interface code wrong");

  ext_drive_a: assert property (
    ext_flag && !enum_mask |=> ENUM_REQ_N_OE && !ENUM_REQ_N_O)
    else $error("extraction not reported on request line");

  ins_reset_a: assert property (
    $past(!RST_N) |-> ins_flag && !ext_flag)
    else $error("status flags wrong after reset");

  ins_clear_a: assert property (
    ctrl_wr && WDATA[23] && !INSERTION_EVENT |=> !ins_flag)
    else $error("insertion flag not cleared by write one");

  keep_on_zero_a: assert property (
    ctrl_wr && !WDATA[22] && ext_flag |=> ext_flag)
    else $error("write zero disturbed extraction flag");

  idle_release_a: assert property (
    !ins_flag && !ext_flag |=> !ENUM_REQ_N_OE)
    else $error("request driven with no flag set");

  irq_level_a: assert property (
    ((INSERTION_EVENT && irq_en[0]) || (EXTRACTION_EVENT && irq_en[1])) && wr_sel != HSC_SEL_IRQ_EN |=> IRQ)
    else $error("interrupt output not raised by enabled event");

  ins_cleared_c: cover property (
    ins_flag ##1 ctrl_wr && WDATA[23] ##2 !ENUM_REQ_N_OE [*2]);

  ext_reported_c: cover property (
    EXTRACTION_EVENT ##2 ENUM_REQ_N_OE ##[1:10] IRQ);

  masked_c: cover property (
    ext_flag && enum_mask ##1 !ENUM_REQ_N_OE);

  set_beats_clr_c: cover property (
    ctrl_wr && WDATA[22] && EXTRACTION_EVENT ##1 ext_flag);

endmodule : hsc_cap_reg

`default_nettype wire

// >>> dv/hsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module hsc_host_model (
  input  wire logic enum_n_o,
  input  wire logic enum_n_oe,
  output var  logic enum_line_n,
  output var  logic enum_seen
);
  // Host side holds a pull-up, so a released line reads high, never the last level
  always_comb
  begin
    enum_line_n = enum_n_oe ? enum_n_o : 1'b1;
    enum_seen   = !enum_line_n;
  end
endmodule : hsc_host_model

`default_nettype wire

// >>> dv/test_hot_swap_capability_register.sv
`timescale 1ns/1ps
`default_nettype none

module test_hot_swap_capability_register;
  import hsc_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        strap;
  logic        ins_ev;
  logic        ext_ev;
  logic        enum_o;
  logic        enum_oe;
  logic        led;
  logic        hide;
  logic        irq;
  logic        line_n;
  logic        seen;
  int          n_errors;
  int          checked;

  hsc_cap_reg DUT (
    .SYS_CLK               (clk),
    .RST_N                 (rst_n),
    .ADDR                  (addr),
    .WDATA                 (wdata),
    .WR                    (wr),
    .RD                    (rd),
    .RDATA                 (rdata),
    .HOT_SWAP_STRAP_ENABLE (strap),
    .INSERTION_EVENT       (ins_ev),
    .EXTRACTION_EVENT      (ext_ev),
    .ENUM_REQ_N_O          (enum_o),
    .ENUM_REQ_N_OE         (enum_oe),
    .LED_ON                (led),
    .DEVICE_HIDE_ARMED     (hide),
    .IRQ                   (irq)
  );

  hsc_host_model host (
    .enum_n_o    (enum_o),
    .enum_n_oe   (enum_oe),
    .enum_line_n (line_n),
    .enum_seen   (seen)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic pulse(input bit extraction_flag);
    @(posedge clk);
    if (extraction_flag)
      ext_ev <= 1'b1;
    else
      ins_ev <= 1'b1;
    @(posedge clk);
    ext_ev <= 1'b0;
    ins_ev <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic close_out;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  logic [31:0] v;

  initial
  begin
    n_errors = 0;
    checked  = 0;
    rst_n    = 1'b0;
    addr     = 8'h00;
    wdata    = 32'h0000_0000;
    wr       = 1'b0;
    rd       = 1'b0;
    strap    = 1'b1;
    ins_ev   = 1'b0;
    ext_ev   = 1'b0;
    do_reset(1'b1);
    chk({31'h0, line_n}, 32'h0000_0000);
    chk({31'h0, seen}, 32'h0000_0001);
    rd_reg(8'h74, v);
    chk(v, 32'h0094_0006);
    $display("reset values done");

    // All ones: status flags cleared, read-only fields untouched
    wr_reg(8'h74, 32'hffff_ffff);
    chk({30'h0, led, hide}, 32'h0000_0003);
    rd_reg(8'h74, v);
    chk(v, 32'h001f_0006);
    chk({31'h0, line_n}, 32'h0000_0001);
    wr_reg(8'h74, 32'h0000_0000);
    rd_reg(8'h74, v);
    chk(v, 32'h0010_0006);
    chk({30'h0, led, hide}, 32'h0000_0000);
    $display("control bits done");

    // Extraction raised with interrupt disabled, then enabled, masked, cleared
    pulse(1'b1);
    chk({31'h0, line_n}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_reg(8'h74, v);
    chk(v, 32'h0054_0006);
    wr_reg(8'h84, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_reg(8'h80, v);
    chk(v, 32'h0000_0002);
    wr_reg(8'h74, 32'h0002_0000);
    @(posedge clk);
    #1;
    chk({31'h0, line_n}, 32'h0000_0001);
    wr_reg(8'h88, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    wr_reg(8'h74, 32'h0042_0000);
    rd_reg(8'h74, v);
    chk(v, 32'h0012_0006);
    $display("extraction done");

    // Strap low gives an empty identifier; unmapped place reads zero
    do_reset(1'b0);
    wr_reg(8'h74, 32'h0080_0000);
    pulse(1'b0);
    chk({31'h0, line_n}, 32'h0000_0000);
    rd_reg(8'h74, v);
    chk(v, 32'h0094_0000);
    wr_reg(8'h90, 32'hffff_ffff);
    rd_reg(8'h90, v);
    chk(v, 32'h0000_0000);
    rd_reg(8'h80, v);
    chk(v, 32'h0000_0001);
    wr_reg(8'h88, 32'h0000_0001);
    rd_reg(8'h80, v);
    chk(v, 32'h0000_0000);
    wr_reg(8'h84, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    pulse(1'b0);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("strap and insertion done");
    close_out();
  end
endmodule : test_hot_swap_capability_register

`default_nettype wire
